/* File: src/capture_pkg.sv */
package capture_pkg;
  // Avalon word index of each register (byte address = 4 * index)
  localparam logic [2:0] IDX_CON1_LO = 3'h0;
  localparam logic [2:0] IDX_CON2_LO = 3'h1;
  localparam logic [2:0] IDX_BUF_LO = 3'h2;
  localparam logic [2:0] IDX_CON1_HI = 3'h3;
  localparam logic [2:0] IDX_CON2_HI = 3'h4;
  localparam logic [2:0] IDX_BUF_HI = 3'h5;
  localparam int unsigned ADDR_W = 5;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned CNT_W = 16;
  localparam int unsigned NUM_TB = 8;
  localparam int unsigned NUM_SRC = 32;
  localparam int unsigned FIFO_DEPTH = 4;
  // First control register fields
  localparam int unsigned C1_MODE_LSB = 0;
  localparam int unsigned C1_BNE_BIT = 3;
  localparam int unsigned C1_OVF_BIT = 4;
  localparam int unsigned C1_IRATE_LSB = 5;
  localparam int unsigned C1_TBSEL_LSB = 10;
  localparam logic [15:0] C1_WMASK = 16'h1C77;
  localparam logic [15:0] C1_RESET = 16'h0000;
  // Second control register fields
  localparam int unsigned C2_SSEL_LSB = 0;
  localparam int unsigned C2_TSTAT_BIT = 6;
  localparam int unsigned C2_TRIG_BIT = 7;
  localparam int unsigned C2_CASC_BIT = 8;
  localparam logic [15:0] C2_WMASK = 16'h019F;
  localparam logic [15:0] C2_RESET = 16'h0000;
  // Capture mode codes
  localparam logic [2:0] MODE_OFF = 3'h0;
  localparam logic [2:0] MODE_EDGE = 3'h1;
  localparam logic [2:0] MODE_RISE = 3'h3;
  localparam logic [2:0] MODE_RISE4 = 3'h4;
  localparam logic [2:0] MODE_RISE16 = 3'h5;
  localparam logic [3:0] PRESC4_LAST = 4'h3;
  localparam logic [3:0] PRESC16_LAST = 4'hF;
  localparam logic [15:0] CNT_MAX = 16'hFFFF;
  localparam logic [2:0] FIFO_FULL = 3'h4;
endpackage : capture_pkg

/* File: src/input_capture_pair.sv */
`timescale 1ns/1ps
// Function
// - Capture the timer value on rising edges or on every pin transition.
// - Rising-edge capture can be every edge, every fourth or every sixteenth.
// - Interrupt-rate field picks events per interrupt, apart from prescaling.
// - Not-empty flag shows FIFO holds data; clears itself when drained.
// - Five-bit source select; zero means no sync or trigger source.
// - Timebase select field picks which timer clock is captured.
// - Trigger bit picks trigger mode; software clears armed status first.
// - Mode field selects capture mode; writing it starts capture.
// - Cascade bit set in both channels, even first, enables 32-bit pairing.
// - In cascade the even channel ignores its own trigger bit.
// - In cascade the odd channel's interrupt rate governs the pair.
// - In cascade the odd channel's trigger bit and mode govern the pair.
// - Cascaded sync pair stays in reset until the sync source is enabled.
// - Capture starts only when timebase and sync source are enabled.
// - Cascaded value: low half in odd buffer, high half in even buffer.
// - Channels run alone with 16-bit counts; only the pair may cascade.
// - In cascade a wrap of the low count increments the high count.
module input_capture_pair (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  // Avalon-MM slave
  input wire logic [capture_pkg::ADDR_W-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [capture_pkg::DATA_W-1:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [capture_pkg::DATA_W-1:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // Capture pins, index 0 odd (low) channel, 1 even (high)
  input wire logic [1:0] capture_input_pin_i,
  // Timebases and sync or trigger sources
  input wire logic [capture_pkg::NUM_TB-1:0] tb_tick_i,
  input wire logic [capture_pkg::NUM_TB-1:0] tb_enable_i,
  input wire logic [capture_pkg::NUM_SRC-1:0] sync_event_i,
  input wire logic [capture_pkg::NUM_SRC-1:0] sync_enable_i,
  // Capture event per channel, one-cycle pulse
  output logic [1:0] capture_event_o
);
  import capture_pkg::*;

  logic ack_ff;
  logic [DATA_W-1:0] rdata_ff;
  logic [2:0] widx;
  logic casc;
  logic wrap0;
  logic [15:0] con1_ff [2];
  logic [15:0] con2_ff [2];
  logic [15:0] cnt_ff [2];
  logic [15:0] mem_ff [2][FIFO_DEPTH];
  logic [1:0] wp_ff [2];
  logic [1:0] rp_ff [2];
  logic [2:0] fcnt_ff [2];
  logic [3:0] pc_ff [2];
  logic [1:0] icnt_ff [2];
  logic [2:0] syn_ff [2];
  logic [1:0] ovf_ff;
  logic [1:0] tst_ff;
  logic [1:0] ev_ff;
  logic [1:0] run;
  logic [1:0] evt;
  logic [1:0] cap;
  logic [1:0] inc;
  logic [1:0] gate;
  logic [1:0] trig_c;
  logic [1:0] sync_hit;
  logic [1:0] bne;
  logic [1:0] push;
  logic [1:0] pop;
  logic [1:0] wr_c1;
  logic [1:0] wr_c2;
  logic [2:0] mode_c [2];
  logic [1:0] irate_c [2];
  logic [4:0] ssel [2];
  logic [2:0] tsel [2];

  function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] wd,
                                        input logic [3:0] be, input logic [15:0] mask);
    logic [15:0] m;
    m = mask & {{8{be[1]}}, {8{be[0]}}};
    merge = (old & ~m) | (wd & m);
  endfunction : merge

  // Bus slave: one wait cycle, then the access is taken
  assign widx = avs_address_i[4:2];
  assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~ack_ff;
  assign avs_readdata_o = rdata_ff;

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= (avs_read_i | avs_write_i) & ~ack_ff;
    end
  end

  // Read data is sampled during the wait cycle; unmapped words read zero
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      rdata_ff <= '0;
    end else if (avs_read_i && !ack_ff) begin
      unique case (widx)
        IDX_CON1_LO: rdata_ff <= {16'h0000, con1_ff[0] | 16'({ovf_ff[0], bne[0]}) << C1_BNE_BIT};
        IDX_CON2_LO: rdata_ff <= {16'h0000, con2_ff[0] | 16'(tst_ff[0]) << C2_TSTAT_BIT};
        IDX_BUF_LO: rdata_ff <= {16'h0000, mem_ff[0][rp_ff[0]]};
        IDX_CON1_HI: rdata_ff <= {16'h0000, con1_ff[1] | 16'({ovf_ff[1], bne[1]}) << C1_BNE_BIT};
        IDX_CON2_HI: rdata_ff <= {16'h0000, con2_ff[1] | 16'(tst_ff[1]) << C2_TSTAT_BIT};
        IDX_BUF_HI: rdata_ff <= {16'h0000, mem_ff[1][rp_ff[1]]};
        default: rdata_ff <= '0;
      endcase
    end
  end

  assign wr_c1[0] = ack_ff & avs_write_i & (widx == IDX_CON1_LO);
  assign wr_c1[1] = ack_ff & avs_write_i & (widx == IDX_CON1_HI);
  assign wr_c2[0] = ack_ff & avs_write_i & (widx == IDX_CON2_LO);
  assign wr_c2[1] = ack_ff & avs_write_i & (widx == IDX_CON2_HI);
  assign pop[0] = ack_ff & avs_read_i & (widx == IDX_BUF_LO) & bne[0];
  assign pop[1] = ack_ff & avs_read_i & (widx == IDX_BUF_HI) & bne[1];

  // Pairing needs both cascade bits, so a half-set pair keeps running alone
  assign casc = con2_ff[0][C2_CASC_BIT] & con2_ff[1][C2_CASC_BIT];
  assign wrap0 = inc[0] & (cnt_ff[0] == CNT_MAX);

  for (genvar i = 0; i < 2; i++) begin : g_ch
    assign ssel[i] = con2_ff[i][C2_SSEL_LSB +: 5];
    assign tsel[i] = con1_ff[i][C1_TBSEL_LSB +: 3];
    assign mode_c[i] = casc ? con1_ff[0][C1_MODE_LSB +: 3] : con1_ff[i][C1_MODE_LSB +: 3];
    assign trig_c[i] = casc ? con2_ff[0][C2_TRIG_BIT] : con2_ff[i][C2_TRIG_BIT];
    assign irate_c[i] = casc ? con1_ff[0][C1_IRATE_LSB +: 2] : con1_ff[i][C1_IRATE_LSB +: 2];
    assign sync_hit[i] = (ssel[i] != 5'h00) & sync_event_i[ssel[i]];
    // Disabled source holds the count at zero, which is the cascaded reset hold
    assign run[i] = (mode_c[i] != MODE_OFF) & tb_enable_i[tsel[i]] &
                    ((ssel[i] == 5'h00) | sync_enable_i[ssel[i]]);
    assign gate[i] = trig_c[i] ? (casc ? tst_ff[0] : tst_ff[i]) : 1'b1;
    if (i == 0) begin : g_lo
      assign inc[i] = tb_tick_i[tsel[i]] & gate[i];
    end else begin : g_hi
      assign inc[i] = casc ? wrap0 : tb_tick_i[tsel[i]] & gate[i];
    end
    assign bne[i] = fcnt_ff[i] != 3'h0;
    assign push[i] = cap[i] & (fcnt_ff[i] != FIFO_FULL);

    always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
        con1_ff[i] <= C1_RESET;
      end else if (wr_c1[i]) begin
        con1_ff[i] <= merge(con1_ff[i], avs_writedata_i[15:0], avs_byteenable_i, C1_WMASK & ~16'h0018);
      end
    end

    always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
        con2_ff[i] <= C2_RESET;
      end else if (wr_c2[i]) begin
        con2_ff[i] <= merge(con2_ff[i], avs_writedata_i[15:0], avs_byteenable_i, C2_WMASK & ~16'h0040);
      end
    end

    // Armed status: a trigger in the clearing cycle wins
    always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
        tst_ff[i] <= 1'b0;
      end else if (trig_c[i] && run[i] && sync_hit[i]) begin
        tst_ff[i] <= 1'b1;
      end else if (wr_c2[i] && avs_byteenable_i[0] && !avs_writedata_i[C2_TSTAT_BIT]) begin
        tst_ff[i] <= 1'b0;
      end
    end

    always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
        cnt_ff[i] <= '0;
      end else if (!run[i]) begin
        cnt_ff[i] <= '0;
      end else if (!trig_c[i] && sync_hit[i]) begin
        cnt_ff[i] <= '0;
      end else if (inc[i]) begin
        cnt_ff[i] <= cnt_ff[i] + 16'h0001;
      end
    end

    // Two-stage synchroniser then an edge stage
    always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
        syn_ff[i] <= 3'h0;
      end else begin
        syn_ff[i] <= {syn_ff[i][1:0], capture_input_pin_i[i]};
      end
    end

    always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
        pc_ff[i] <= '0;
      end else if (!run[i] || wr_c1[i]) begin
        pc_ff[i] <= '0;
      end else if (syn_ff[i][1] && !syn_ff[i][2]) begin
        if ((mode_c[i] == MODE_RISE4 && pc_ff[i] == PRESC4_LAST) ||
            (mode_c[i] == MODE_RISE16 && pc_ff[i] == PRESC16_LAST)) begin
          pc_ff[i] <= '0;
        end else begin
          pc_ff[i] <= pc_ff[i] + 4'h1;
        end
      end
    end

    always_comb begin
      evt[i] = 1'b0;
      if (run[i]) begin
        unique case (mode_c[i])
          MODE_EDGE: evt[i] = syn_ff[i][1] ^ syn_ff[i][2];
          MODE_RISE: evt[i] = syn_ff[i][1] & ~syn_ff[i][2];
          MODE_RISE4: evt[i] = syn_ff[i][1] & ~syn_ff[i][2] & (pc_ff[i] == PRESC4_LAST);
          MODE_RISE16: evt[i] = syn_ff[i][1] & ~syn_ff[i][2] & (pc_ff[i] == PRESC16_LAST);
          default: evt[i] = 1'b0;
        endcase
      end
    end

    // Cascaded pair captures on the odd channel's pin and mode together
    assign cap[i] = (casc ? evt[0] : evt[i]) & run[i];

    always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
        wp_ff[i] <= '0;
      end else if (push[i]) begin
        mem_ff[i][wp_ff[i]] <= cnt_ff[i];
        wp_ff[i] <= wp_ff[i] + 2'h1;
      end
    end

    always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
        rp_ff[i] <= '0;
      end else if (pop[i]) begin
        rp_ff[i] <= rp_ff[i] + 2'h1;
      end
    end

    always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
        fcnt_ff[i] <= '0;
      end else if (push[i] && !pop[i]) begin
        fcnt_ff[i] <= fcnt_ff[i] + 3'h1;
      end else if (pop[i] && !push[i]) begin
        fcnt_ff[i] <= fcnt_ff[i] - 3'h1;
      end
    end

    // Full FIFO drops the new capture and flags it; a new event wins over clear
    always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
        ovf_ff[i] <= 1'b0;
      end else if (cap[i] && !push[i]) begin
        ovf_ff[i] <= 1'b1;
      end else if (wr_c1[i] && avs_byteenable_i[0] && !avs_writedata_i[C1_OVF_BIT]) begin
        ovf_ff[i] <= 1'b0;
      end
    end

    always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
        icnt_ff[i] <= '0;
        ev_ff[i] <= 1'b0;
      end else begin
        ev_ff[i] <= 1'b0;
        if (wr_c1[i] || !run[i]) begin
          icnt_ff[i] <= '0;
        end else if (cap[i]) begin
          if (icnt_ff[i] == irate_c[i]) begin
            icnt_ff[i] <= '0;
            ev_ff[i] <= (i == 0) || !casc;
          end else begin
            icnt_ff[i] <= icnt_ff[i] + 2'h1;
          end
        end
      end
    end
  end

  assign capture_event_o = ev_ff;

  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (sys_rst_i);

  a_bne_clears: assert property ((fcnt_ff[0] == 3'h1 && pop[0] && !push[0]) |=> !bne[0])
    else $error("not-empty flag did not clear after last read");
  a_every_edge: assert property ((!casc && run[0] && mode_c[0] == MODE_EDGE && syn_ff[0][1] != syn_ff[0][2])
      |-> cap[0])
    else $error("transition not captured");
  a_presc_sixteen: assert property ((!casc && mode_c[0] == MODE_RISE16 && cap[0]) |-> pc_ff[0] == 4'hF)
    else $error("sixteenth-edge prescale wrong");
  a_irate_each: assert property ((!casc && run[0] && !wr_c1[0] && cap[0] && irate_c[0] == 2'h0 && icnt_ff[0] == 2'h0)
      |=> capture_event_o[0])
    else $error("event not signalled at rate one");
  a_run_gate: assert property (!run[0] |=> cnt_ff[0] == 16'h0000)
    else $error("count advanced while not enabled");
  a_casc_wrap: assert property ((casc && run[1] && wrap0 && !sync_hit[1]) |=> cnt_ff[1] == $past(cnt_ff[1]) + 16'h0001)
    else $error("low wrap did not carry");
  a_odd_irq: assert property ((casc && $past(casc)) |-> !capture_event_o[1])
    else $error("even channel signalled in cascade");
  a_sync_clear: assert property ((run[0] && !trig_c[0] && sync_hit[0]) |=> cnt_ff[0] == 16'h0000)
    else $error("sync did not clear count");
  a_trig_hold: assert property ((run[0] && trig_c[0] && !gate[0]) |=> $stable(cnt_ff[0]))
    else $error("count ran before trigger");
endmodule : input_capture_pair

/* File: testbench/capture_far_model.sv */
`timescale 1ns/1ps
module capture_far_model (
  // Clock
  input wire logic core_clk_i,
  // Pin and timebase ticks
  output logic [1:0] pin_o,
  output logic [7:0] tick_o
);
  initial begin
    pin_o = 2'h0;
    tick_o = 8'h00;
  end
  // Ticks run back to back so a full wrap of the count stays short in time
  task automatic ticks(input int sel, input int n);
    @(posedge core_clk_i) tick_o <= 8'(8'h01 << sel);
    repeat (n - 1) @(posedge core_clk_i);
    @(posedge core_clk_i) tick_o <= 8'h00;
  endtask : ticks
  // Level held until the synchroniser and the capture have finished
  task automatic flip(input int ch);
    @(posedge core_clk_i) pin_o[ch] <= ~pin_o[ch];
    repeat (5) @(posedge core_clk_i);
  endtask : flip
endmodule : capture_far_model

/* File: testbench/input_capture_pair_tb.sv */
`timescale 1ns/1ps
module input_capture_pair_tb;
  import capture_pkg::*;
  localparam logic [4:0] A1L = {IDX_CON1_LO, 2'h0};
  localparam logic [4:0] A2L = {IDX_CON2_LO, 2'h0};
  localparam logic [4:0] ABL = {IDX_BUF_LO, 2'h0};
  localparam logic [4:0] A1H = {IDX_CON1_HI, 2'h0};
  localparam logic [4:0] A2H = {IDX_CON2_HI, 2'h0};
  localparam logic [4:0] ABH = {IDX_BUF_HI, 2'h0};
  logic core_clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [ADDR_W-1:0] avs_address_i = '0;
  logic avs_read_i = 1'b0;
  logic avs_write_i = 1'b0;
  logic [DATA_W-1:0] avs_writedata_i = '0;
  logic [DATA_W-1:0] avs_readdata_o;
  logic avs_waitrequest_o;
  logic [1:0] pin;
  logic [1:0] ev;
  logic [NUM_TB-1:0] tick;
  logic [3:0] be = 4'hF;
  logic [NUM_TB-1:0] tb_en = '1;
  logic [NUM_SRC-1:0] sync_event_i = '0;
  logic [NUM_SRC-1:0] sync_enable_i = '0;
  logic [32:0] exp_q[$];
  logic [32:0] e;
  logic [31:0] q;
  // Xorshift seed 47
  logic [31:0] rnd = 32'h0000002F;
  int err_count = 0;
  int tests_run = 0;
  int ev0 = 0;
  int ev1 = 0;
  int n, n1, n2;
  int flips[4] = '{4, 16, 32, 4};
  int evs[4] = '{2, 2, 1, 2};
  int fill[4] = '{2, 2, 1, 4};
  logic [15:0] cfg[4] = '{16'h0003, 16'h0004, 16'h0005, 16'h0021};
  always #12.5 core_clk_i = ~core_clk_i;
  input_capture_pair u_dut (
    .core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_byteenable_i(be), .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
    .capture_input_pin_i(pin), .tb_tick_i(tick), .tb_enable_i(tb_en),
    .sync_event_i(sync_event_i), .sync_enable_i(sync_enable_i), .capture_event_o(ev)
  );
  capture_far_model u_far (.core_clk_i(core_clk_i), .pin_o(pin), .tick_o(tick));
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction : xs
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic finish_test();
    $display("checks %0d errors %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : finish_test
  // Events are counted and read data judged where both are settled
  always @(negedge core_clk_i) begin
    if (ev[0] === 1'b1) ev0++;
    if (ev[1] === 1'b1) ev1++;
    if (avs_read_i && avs_waitrequest_o === 1'b0 && exp_q.size() > 0) begin
      e = exp_q.pop_front();
      if (e[32]) check("readdata", avs_readdata_o, e[31:0]);
    end
  end
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d, input logic [32:0] x);
    int k;
    if (!w) exp_q.push_back(x);
    @(posedge core_clk_i);
    avs_address_i <= a;
    avs_read_i <= !w;
    avs_write_i <= w;
    avs_writedata_i <= d;
    // Waitrequest and read data are taken at the rising edge that ends the access
    for (k = 0; k < 20; k++) begin
      @(posedge core_clk_i);
      if (avs_waitrequest_o === 1'b0) break;
    end
    q = avs_readdata_o;
    if (k == 20) begin
      err_count++;
      finish_test();
    end
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
  endtask : bus
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    bus(1'b1, a, {16'h0000, d}, 33'h0);
  endtask : wr
  task automatic rd(input logic [4:0] a, input logic [15:0] x);
    bus(1'b0, a, 32'h0, {1'b1, 16'h0000, x});
  endtask : rd
  task automatic drain(output int cnt);
    cnt = 0;
    for (int i = 0; i < 8; i++) begin
      bus(1'b0, A1L, 32'h0, 33'h0);
      if (q[C1_BNE_BIT] !== 1'b1) break;
      bus(1'b0, ABL, 32'h0, 33'h0);
      cnt++;
    end
  endtask : drain
  task automatic pulse();
    @(posedge core_clk_i) sync_event_i[3] <= 1'b1;
    @(posedge core_clk_i) sync_event_i[3] <= 1'b0;
  endtask : pulse
  initial begin
    repeat (5) @(posedge core_clk_i);
    sys_rst_i <= 1'b0;
    rd(A1L, C1_RESET);
    rd(A2L, C2_RESET);
    wr(5'h1C, 16'hFFFF);
    rd(5'h1C, 16'h0000);
    wr(A1L, 16'h1C6B);
    rd(A1L, 16'h1C63);
    // Only the low byte lane lands, so the timebase field keeps its value
    be <= 4'h1;
    wr(A1L, 16'hFFFF);
    be <= 4'hF;
    rd(A1L, 16'h1C67);
    wr(A2L, 16'h019F);
    rd(A2L, 16'h019F);
    wr(A2L, 16'h0000);
    wr(A1L, 16'h0000);
    // Every transition on timebase 2; ticks on timebase 0 must not count
    wr(A1L, 16'h0801);
    rnd = xs(rnd);
    n1 = 1 + rnd[2:0];
    rnd = xs(rnd);
    n2 = 1 + rnd[2:0];
    ev0 = 0;
    u_far.ticks(2, n1);
    u_far.ticks(0, 5);
    u_far.flip(0);
    u_far.ticks(2, n2);
    u_far.flip(0);
    check("events", 32'(ev0), 32'h2);
    rd(A1L, 16'h0809);
    rd(ABL, n1[15:0]);
    rd(ABL, 16'(n1 + n2));
    rd(A1L, 16'h0801);
    for (int i = 0; i < 4; i++) begin
      wr(A1L, 16'h0000);
      ev0 = 0;
      wr(A1L, cfg[i]);
      repeat (flips[i]) u_far.flip(0);
      check("events", 32'(ev0), 32'(evs[i]));
      drain(n);
      check("fifo depth", 32'(n), 32'(fill[i]));
    end
    wr(A1L, 16'h0000);
    sync_enable_i <= '0;
    wr(A2L, 16'h0003);
    wr(A1L, 16'h0001);
    ev0 = 0;
    u_far.flip(0);
    check("events", 32'(ev0), 32'h0);
    // Source enabled but timebase off: still no capture
    tb_en[0] <= 1'b0;
    rnd = xs(rnd);
    sync_enable_i <= {rnd[31:4], 1'b1, rnd[2:0]};
    u_far.flip(0);
    check("events", 32'(ev0), 32'h0);
    tb_en[0] <= 1'b1;
    u_far.ticks(0, 3);
    pulse();
    u_far.ticks(0, 6);
    u_far.flip(0);
    rd(ABL, 16'h0006);
    wr(A1L, 16'h0000);
    wr(A2L, 16'h0083);
    wr(A1L, 16'h0001);
    u_far.ticks(0, 4);
    pulse();
    u_far.ticks(0, 2);
    u_far.flip(0);
    rd(A2L, 16'h00C3);
    rd(ABL, 16'h0002);
    wr(A1L, 16'h0000);
    wr(A2L, 16'h0000);
    // Cascade: even channel first, then odd; a full low wrap plus one
    wr(A2H, 16'h0100);
    wr(A2L, 16'h0100);
    wr(A1H, 16'h0001);
    wr(A1L, 16'h0001);
    ev0 = 0;
    ev1 = 0;
    u_far.ticks(0, 65537);
    u_far.flip(0);
    check("low events", 32'(ev0), 32'h1);
    check("high events", 32'(ev1), 32'h0);
    rd(ABL, 16'h0001);
    rd(ABH, 16'h0001);
    finish_test();
  end
endmodule : input_capture_pair_tb
